// File: rtl/amtl_pkg.sv
// Purpose: shared constants and types for the multi-turn limit block
// Assumes: 32-bit register port, one clock
// Notes: offsets are word indices times four
package amtl_pkg;
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_WRAP_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_HOME_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_PROTECT = 8'h0C;
  localparam logic [7:0] ADDR_UTIL_CMD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
  localparam logic [7:0] ADDR_TURN_COUNT = 8'h20;
  localparam logic [7:0] ADDR_FEEDBACK = 8'h24;
  localparam logic [7:0] ADDR_ENC_LIMIT = 8'h28;
  localparam logic [15:0] WRAP_LIMIT_RESET = 16'hFFFF;
  localparam logic [15:0] WRAP_LIMIT_SIGNED = 16'hFFFF;
  localparam logic [15:0] ENC_LIMIT_RESET = 16'hFFFF;
  localparam logic [3:0] PROTECT_RESET = 4'h0;
  localparam logic [3:0] PROTECT_ON = 4'h1;
  localparam logic [3:0] USAGE_ABSOLUTE = 4'h0;
  localparam logic [3:0] USAGE_INCREMENTAL = 4'h1;
  localparam logic [31:0] HOME_OFFSET_RESET = 32'h0000_0000;
  localparam logic [31:0] HOME_OFFSET_MAX = 32'h3FFF_FFFF;
  localparam logic [31:0] HOME_OFFSET_MIN = 32'hC000_0001;
  localparam int IRQ_MISMATCH = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_REFUSED = 2;
  localparam int IRQ_WIDTH = 3;
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } amtl_bus_s;
  // encoder side position sample
  typedef struct packed {
    logic [31:0] position;
    logic zero_cross;
    logic dir_neg;
  } amtl_enc_s;
endpackage : amtl_pkg

// File: rtl/amtl_core.sv
// Summary of operation
// - usage digit 0 means absolute encoder, 1 means incremental.
// - wrap limit accepts 0..65535 revolutions, default 65535.
// - a written wrap limit takes effect only after control power restart.
// - limit 65535 makes the turn count signed, -32768 to 32767.
// - other limits keep the turn count between 0 and the limit.
// - count 0 turning negative wraps to the limit.
// - count at the limit turning positive wraps to zero.
// - alarm raised while encoder limit differs from the active drive limit.
// - encoder limit write allowed only while the mismatch alarm is active.
// - write-protect value 0001 refuses the utility with a refused flag.
// - utility completion reports done and clears alarm; encoder limit needs restart.
// - absolute mode feedback is encoder position plus signed home offset.
//
// Purpose: multi-turn revolution counter with wrap limit, mismatch alarm and home offset
// Assumes: encoder inputs come from another domain; power_restart pulse marks a power cycle
// Notes: encoder limit storage models the encoder's own nonvolatile copy
module amtl_core (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire amtl_pkg::amtl_bus_s bus,
  output logic [31:0] rdata,
  // encoder side
  input wire amtl_pkg::amtl_enc_s enc,
  input wire logic power_restart,
  // results
  output logic [15:0] turn_count,
  output logic [31:0] feedback_position,
  output logic limit_mismatch_alarm,
  output logic irq
);
  import amtl_pkg::*;

  // configuration as written by software
  logic [3:0] encoder_usage_select;
  logic [15:0] turn_wrap_limit;
  logic [31:0] home_offset;
  logic [3:0] write_protect_setting;
  // settings latched at restart, then utility and interrupt state
  logic [3:0] active_usage;
  logic [15:0] active_limit;
  logic [15:0] enc_limit_stored;
  logic [15:0] enc_limit_pending;
  logic util_done;
  logic refused_indication;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;
  // encoder and power restart synchronisers
  amtl_enc_s enc_s1;
  amtl_enc_s enc_s2;
  logic cross_d;
  logic restart_s1;
  logic restart_s2;
  logic restart_d;
  logic [31:0] pos_s3;
  logic [31:0] pos_stable;

  // register decode
  wire wr_cfg = bus.wr && bus.addr == ADDR_CONFIG;
  wire wr_lim = bus.wr && bus.addr == ADDR_WRAP_LIMIT;
  wire wr_off = bus.wr && bus.addr == ADDR_HOME_OFFSET;
  wire wr_prot = bus.wr && bus.addr == ADDR_PROTECT;
  wire wr_util = bus.wr && bus.addr == ADDR_UTIL_CMD && bus.wdata[0];
  wire wr_mask = bus.wr && bus.addr == ADDR_IRQ_MASK;
  wire rd_irq = bus.rd && bus.addr == ADDR_IRQ_STATUS;

  // utility gating: protect first, then alarm state
  wire util_refuse = wr_util && (write_protect_setting == PROTECT_ON);
  wire util_go = wr_util && !util_refuse && limit_mismatch_alarm;
  wire util_reject = wr_util && !util_refuse && !limit_mismatch_alarm;

  // restart and turn events, from the second sync stage only
  wire restart_pulse = restart_s2 && !restart_d;
  wire turn_step = enc_s2.zero_cross && !cross_d;
  wire signed_mode = active_limit == WRAP_LIMIT_SIGNED;

  // alarm compares the encoder copy with the limit in force
  wire mismatch_now = enc_limit_stored != active_limit;
  wire next_alarm = mismatch_now && !util_go && !util_done;

  // home offset clamped to its documented span
  wire signed [31:0] off_in = bus.wdata;
  wire off_hi = off_in > $signed(HOME_OFFSET_MAX);
  wire off_lo = off_in < $signed(HOME_OFFSET_MIN);
  wire [31:0] next_offset = off_hi ? HOME_OFFSET_MAX : (off_lo ? HOME_OFFSET_MIN : bus.wdata);

  // next turn count with wrap in both directions
  logic [15:0] next_count;
  always_comb begin
    next_count = turn_count;
    if (turn_step) begin
      if (enc_s2.dir_neg) begin
        if (!signed_mode && turn_count == 16'h0000) begin
          next_count = active_limit;
        end else begin
          next_count = turn_count - 16'h0001;
        end
      end else begin
        if (!signed_mode && turn_count >= active_limit) begin
          next_count = 16'h0000;
        end else begin
          next_count = turn_count + 16'h0001;
        end
      end
    end
  end

  // feedback: offset only applies in absolute use
  wire absolute_use = active_usage == USAGE_ABSOLUTE;
  // a word from another clock may be caught mid-change, so only a
  // value seen alike in two cycles running is passed on
  wire pos_settled = enc_s2.position == pos_s3;
  wire [31:0] next_feedback = absolute_use ? pos_stable + home_offset
                                           : pos_stable;

  // interrupt events
  wire [IRQ_WIDTH-1:0] irq_event = {util_refuse | util_reject, util_go,
                                    next_alarm & !limit_mismatch_alarm};
  // read clear first, new events on top so none is lost
  wire [IRQ_WIDTH-1:0] irq_kept = rd_irq ? {IRQ_WIDTH{1'b0}} : irq_status;
  wire [IRQ_WIDTH-1:0] next_irq_status = irq_kept | irq_event;
  wire next_irq = |(next_irq_status & irq_mask);

  // read mux
  logic [31:0] next_rdata;
  always_comb begin
    case (bus.addr)
      ADDR_CONFIG: next_rdata = {28'h0000000, encoder_usage_select};
      ADDR_WRAP_LIMIT: next_rdata = {16'h0000, turn_wrap_limit};
      ADDR_HOME_OFFSET: next_rdata = home_offset;
      ADDR_PROTECT: next_rdata = {28'h0000000, write_protect_setting};
      ADDR_STATUS: next_rdata = {28'h0000000, refused_indication, util_done,
                                 signed_mode, limit_mismatch_alarm};
      ADDR_IRQ_STATUS: next_rdata = {29'h0000000, irq_status};
      ADDR_IRQ_MASK: next_rdata = {29'h0000000, irq_mask};
      ADDR_TURN_COUNT: next_rdata = {16'h0000, turn_count};
      ADDR_FEEDBACK: next_rdata = feedback_position;
      ADDR_ENC_LIMIT: next_rdata = {16'h0000, enc_limit_stored};
      default: next_rdata = 32'h0000_0000;
    endcase
    if (!bus.rd) begin
      next_rdata = 32'h0000_0000;
    end
  end

  // synchronisers for pins from the encoder and power supervisor
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      enc_s1 <= '0;
      enc_s2 <= '0;
      cross_d <= 1'b0;
      restart_s1 <= 1'b0;
      restart_s2 <= 1'b0;
      restart_d <= 1'b0;
    end else begin
      enc_s1 <= enc;
      enc_s2 <= enc_s1;
      cross_d <= enc_s2.zero_cross;
      restart_s1 <= power_restart;
      restart_s2 <= restart_s1;
      restart_d <= restart_s2;
    end
  end

  // third stage and hold register for the position word
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pos_s3 <= 32'h0000_0000;
      pos_stable <= 32'h0000_0000;
    end else begin
      pos_s3 <= enc_s2.position;
      if (pos_settled) begin
        pos_stable <= pos_s3;
      end
    end
  end

  // software-written settings
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      encoder_usage_select <= USAGE_ABSOLUTE;
      turn_wrap_limit <= WRAP_LIMIT_RESET;
      home_offset <= HOME_OFFSET_RESET;
      write_protect_setting <= PROTECT_RESET;
      irq_mask <= '0;
    end else begin
      if (wr_cfg) begin
        encoder_usage_select <= bus.wdata[3:0];
      end
      if (wr_lim) begin
        turn_wrap_limit <= bus.wdata[15:0];
      end
      if (wr_off) begin
        home_offset <= next_offset;
      end
      if (wr_prot) begin
        write_protect_setting <= bus.wdata[3:0];
      end
      if (wr_mask) begin
        irq_mask <= bus.wdata[IRQ_WIDTH-1:0];
      end
    end
  end

  // settings that only a restart brings into force
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      active_usage <= USAGE_ABSOLUTE;
      active_limit <= WRAP_LIMIT_RESET;
      enc_limit_stored <= ENC_LIMIT_RESET;
      enc_limit_pending <= ENC_LIMIT_RESET;
    end else begin
      if (util_go) begin
        enc_limit_pending <= turn_wrap_limit;
      end
      if (restart_pulse) begin
        active_usage <= encoder_usage_select;
        active_limit <= turn_wrap_limit;
        enc_limit_stored <= enc_limit_pending;
      end
    end
  end

  // utility done holds until restart; a run in the restart cycle still counts
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      util_done <= 1'b0;
    end else begin
      if (util_go) begin
        util_done <= 1'b1;
      end else if (restart_pulse) begin
        util_done <= 1'b0;
      end
    end
  end

  // refused flag reflects the latest utility attempt only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      refused_indication <= 1'b0;
    end else begin
      if (wr_util) begin
        refused_indication <= util_refuse;
      end
    end
  end

  // mismatch alarm level
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      limit_mismatch_alarm <= 1'b0;
    end else begin
      limit_mismatch_alarm <= next_alarm;
    end
  end

  // turn count; a restart starts counting from zero again
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      turn_count <= 16'h0000;
    end else begin
      turn_count <= restart_pulse ? 16'h0000 : next_count;
    end
  end

  // feedback position register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      feedback_position <= 32'h0000_0000;
    end else begin
      feedback_position <= next_feedback;
    end
  end

  // read data register, zero outside the answer cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // sticky interrupt bits and the level output
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= next_irq;
    end
  end
endmodule : amtl_core

// File: dv/amtl_core_properties.sv
// Purpose: port-level checks for the multi-turn limit block
// Assumes: one clock, async low reset, inputs held by the bench
// Notes: crossing and alarm-rise sync delays get one cycle of slack either side
module amtl_core_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire amtl_pkg::amtl_bus_s bus,
  input wire logic [31:0] rdata,
  // encoder side
  input wire amtl_pkg::amtl_enc_s enc,
  input wire logic power_restart,
  // results
  input wire logic [15:0] turn_count,
  input wire logic [31:0] feedback_position,
  input wire logic limit_mismatch_alarm,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  import amtl_pkg::*;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  a_rdata_idle:
    assert property (!$past(bus.rd) |-> rdata == 32'h0) else $error("stray read data");
  a_limit_read:
    assert property (bus.rd && bus.addr == ADDR_WRAP_LIMIT |=> rdata[31:16] == 16'h0)
    else $error("wrap limit wider than 16 bits");
  a_count_read:
    assert property (bus.rd && bus.addr == ADDR_TURN_COUNT |=> rdata == {16'h0, $past(turn_count)})
    else $error("turn count read wrong");
  a_status_read:
    assert property (bus.rd && bus.addr == ADDR_STATUS |=>
      rdata[31:4] == 28'h0 && rdata[0] == $past(limit_mismatch_alarm))
    else $error("status alarm bit wrong");
  // count moves only after a crossing or a restart reaches the core
  a_count_cause:
    assert property ($changed(turn_count) |-> $past(enc.zero_cross, 2) ||
      $past(enc.zero_cross, 3) || $past(enc.zero_cross, 4) || $past(power_restart, 3))
    else $error("turn count moved without a crossing");
  a_restart_zero:
    assert property ($rose(power_restart) |-> ##[2:5] turn_count == 16'h0)
    else $error("restart left turn count");
  a_alarm_rise:
    assert property ($rose(limit_mismatch_alarm) |-> $past(power_restart, 3) ||
      $past(power_restart, 4) || $past(power_restart, 5))
    else $error("alarm rose without restart");
  a_alarm_fall:
    assert property ($fell(limit_mismatch_alarm) |->
      ($past(bus.wr) && $past(bus.addr) == ADDR_UTIL_CMD) || $past(power_restart, 4))
    else $error("alarm fell without utility");
endmodule : amtl_core_chk

bind amtl_core amtl_core_chk i_chk (
  .mclk(mclk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .enc(enc),
  .power_restart(power_restart), .turn_count(turn_count),
  .feedback_position(feedback_position), .limit_mismatch_alarm(limit_mismatch_alarm),
  .irq(irq)
);

// File: dv/amtl_enc_model.sv
// Purpose: encoder stand-in making one turn step per request
// Assumes: step is a one-cycle request from the bench
// Notes: crossing held two cycles so the sync flops never miss it
module amtl_enc_model (
  // clock
  input wire logic mclk,
  // request
  input wire logic step,
  input wire logic neg,
  input wire logic [31:0] pos,
  // encoder pins
  output amtl_pkg::amtl_enc_s enc
);
  timeunit 1ns;
  timeprecision 100ps;
  import amtl_pkg::*;
  logic [1:0] hold = 2'h0;
  // pulse stretcher for the zero crossing
  always_ff @(posedge mclk) begin
    hold <= step ? 2'h3 : {hold[0], 1'b0};
  end
  assign enc = '{position: pos, zero_cross: hold[1], dir_neg: neg};
endmodule : amtl_enc_model

// File: dv/absolute_multiturn_limit_tb.sv
// Purpose: register-driven test of wrap, alarm, utility and offset
// Assumes: restart pin emulates a control power cycle
// Notes: expected values worked out by hand from the limits
module absolute_multiturn_limit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import amtl_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic power_restart = 1'b0;
  logic step = 1'b0;
  logic neg = 1'b0;
  logic [31:0] pos = 32'h0;
  amtl_bus_s bus = '0;
  amtl_enc_s enc;
  logic [31:0] rdata;
  logic [31:0] feedback_position;
  logic [15:0] turn_count;
  logic limit_mismatch_alarm;
  logic irq;
  int n_fail = 0;
  int checked = 0;
  always #2.5 mclk = ~mclk;
  amtl_enc_model i_enc (.mclk(mclk), .step(step), .neg(neg), .pos(pos), .enc(enc));
  amtl_core i_dut (.mclk(mclk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .enc(enc),
    .power_restart(power_restart), .turn_count(turn_count),
    .feedback_position(feedback_position), .limit_mismatch_alarm(limit_mismatch_alarm),
    .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
    #1;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd
  task automatic turn(input logic n, input logic [15:0] exp);
    @(posedge mclk);
    step <= 1'b1;
    neg <= n;
    @(posedge mclk);
    step <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    chk({16'h0, turn_count}, {16'h0, exp});
  endtask : turn
  task automatic restart;
    @(posedge mclk);
    power_restart <= 1'b1;
    repeat (8) @(posedge mclk);
    power_restart <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask : restart
  task automatic complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // hang guard, run needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    wr(ADDR_IRQ_MASK, 32'h7);
    rd(ADDR_WRAP_LIMIT, 32'hFFFF);
    rd(ADDR_ENC_LIMIT, 32'hFFFF);
    rd(8'h3C, 32'h0);
    turn(1'b1, 16'hFFFF);
    turn(1'b0, 16'h0);
    wr(ADDR_WRAP_LIMIT, 32'h3);
    turn(1'b1, 16'hFFFF);
    chk({31'h0, limit_mismatch_alarm}, 32'h0);
    restart();
    chk({31'h0, limit_mismatch_alarm}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(ADDR_STATUS, 32'h1);
    rd(ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge mclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    turn(1'b1, 16'h3);
    turn(1'b0, 16'h0);
    turn(1'b0, 16'h1);
    rd(ADDR_TURN_COUNT, 32'h1);
    wr(ADDR_PROTECT, 32'h1);
    rd(ADDR_PROTECT, 32'h1);
    wr(ADDR_UTIL_CMD, 32'h1);
    rd(ADDR_STATUS, 32'h9);
    rd(ADDR_IRQ_STATUS, 32'h4);
    wr(ADDR_PROTECT, 32'h0);
    wr(ADDR_UTIL_CMD, 32'h1);
    chk({31'h0, limit_mismatch_alarm}, 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h2);
    rd(ADDR_STATUS, 32'h4);
    wr(ADDR_UTIL_CMD, 32'h1);
    rd(ADDR_IRQ_STATUS, 32'h4);
    restart();
    rd(ADDR_ENC_LIMIT, 32'h3);
    chk({31'h0, limit_mismatch_alarm}, 32'h0);
    @(posedge mclk);
    pos <= 32'h64;
    repeat (6) @(posedge mclk);
    #1;
    chk(feedback_position, 32'h64);
    wr(ADDR_HOME_OFFSET, 32'h7FFF_FFFF);
    rd(ADDR_HOME_OFFSET, 32'h3FFF_FFFF);
    wr(ADDR_HOME_OFFSET, 32'h8000_0000);
    rd(ADDR_HOME_OFFSET, 32'hC000_0001);
    wr(ADDR_HOME_OFFSET, 32'hFFFF_FF9C);
    repeat (4) @(posedge mclk);
    #1;
    chk(feedback_position, 32'h0);
    rd(ADDR_HOME_OFFSET, 32'hFFFF_FF9C);
    rd(ADDR_FEEDBACK, 32'h0);
    wr(ADDR_CONFIG, 32'h1);
    rd(ADDR_CONFIG, 32'h1);
    restart();
    chk(feedback_position, 32'h64);
    complete_run();
  end
endmodule : absolute_multiturn_limit_tb
